// *** bench/diag_indicator_ctrl_tb_top.sv ***
// Self-checking bench for the diagnostic indicator and buzzer control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module diag_indicator_ctrl_tb_top;
    import diag_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ------------------------------------------------------------------
    logic              i_clk   = 1'b0;   // 10 MHz system clock
    logic              i_nrst  = 1'b0;   // Synchronous reset, active low
    logic [ADDR_W-1:0] i_addr  = 8'h00;  // Register offset
    logic [DATA_W-1:0] i_wdata = 8'h00;  // Write data
    logic              i_wr    = 1'b0;   // Write strobe
    logic              i_rd    = 1'b0;   // Read strobe
    logic [DATA_W-1:0] o_rdata;          // Read data
    logic              o_led;            // Indicator drive
    logic              o_buzzer;         // Buzzer drive
    logic [ADDR_W-1:0] off;              // Offset used in the code sweep
    logic [DATA_W-1:0] code;             // Value used in the code sweep
    int                num_errors = 0;   // Mismatches seen
    int                n_compared = 0;   // Comparisons made
    int                cycles     = 0;   // Clock cycles since time zero
    int                lows       = 0;   // Cycles an enabled output was dark
    // Ceiling well above the planned run of about 25000 cycles
    localparam int LIMIT = 60000;

    // Half period of 50 ns gives 100 ns per cycle
    always #50 i_clk = ~i_clk;

    diag_indicator_ctrl u_diag_indicator_ctrl (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_addr   (i_addr),
        .i_wdata  (i_wdata),
        .i_wr     (i_wr),
        .i_rd     (i_rd),
        .o_rdata  (o_rdata),
        .o_led    (o_led),
        .o_buzzer (o_buzzer)
    );

    // Hang guard: a run that outlives the ceiling counts as a mismatch
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            num_errors++;
            $display("Cycle ceiling reached");
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Register bus tasks
    // ------------------------------------------------------------------
    // One-cycle write strobe; returns just after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data stand only in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        `CHK(nm, exp, o_rdata)
        @(posedge i_clk);
        #1;
        `CHK("read data idle", READ_ZERO, o_rdata)
    endtask

    // Write a register, then watch its output change on the second edge after the write is taken, exactly
    task automatic pulse_chk(input logic [7:0] a, input logic [7:0] d, input logic exp);
        wr(a, d);
        @(posedge i_clk);
        #1;
        `CHK("output before latency", ~exp, (a == OFF_INDICATOR) ? o_led : o_buzzer)
        @(posedge i_clk);
        #1;
        `CHK("output after latency", exp, (a == OFF_INDICATOR) ? o_led : o_buzzer)
    endtask

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        // Registers and outputs come out of reset cleared
        #1;
        `CHK("led after reset", 1'b0, o_led)
        `CHK("buzzer after reset", 1'b0, o_buzzer)
        rd_chk(OFF_INDICATOR, 8'h00, "indicator reset");
        rd_chk(OFF_SOUNDER, 8'h00, "sounder reset");
        $display("Test reset values done");

        // Every pattern code on both registers: lit at once, read back, dark when disabled
        for (int k = 0; k < 8; k++)
        begin
            off  = k[0] ? OFF_SOUNDER : OFF_INDICATOR;
            code = {5'h00, k[2:1], 1'b1};
            pulse_chk(off, code, 1'b1);
            rd_chk(off, code, "pattern readback");
            pulse_chk(off, code & 8'hFE, 1'b0);
            rd_chk(off, code & 8'hFE, "disabled readback");
        end
        $display("Test pattern codes done");

        // Upper bits are not stored; unmapped offsets ignore writes and read zero
        pulse_chk(OFF_INDICATOR, 8'hFF, 1'b1);
        rd_chk(OFF_INDICATOR, 8'h07, "indicator upper bits");
        wr(OFF_SOUNDER, 8'hF8);
        rd_chk(OFF_SOUNDER, 8'h00, "sounder upper bits");
        `CHK("buzzer with upper bits only", 1'b0, o_buzzer)
        wr(8'h61, 8'hFF);
        wr(8'h64, 8'hFF);
        rd_chk(8'h61, 8'h00, "unmapped below");
        rd_chk(8'h64, 8'h00, "unmapped above");
        rd_chk(OFF_SOUNDER, 8'h00, "sounder untouched");
        $display("Test reserved and unmapped done");

        // Continuous beep never drops; short blink stays lit well inside its on-time
        pulse_chk(OFF_SOUNDER, 8'h01, 1'b1);
        repeat (25000)
        begin
            @(posedge i_clk);
            #1;
            if (o_buzzer !== 1'b1 || o_led !== 1'b1)
                lows++;
        end
        `CHK("dark cycles while lit", 0, lows)
        $display("Test steady output done");

        // Reset in mid-run clears both registers and both outputs
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1;
        `CHK("led after second reset", 1'b0, o_led)
        `CHK("buzzer after second reset", 1'b0, o_buzzer)
        rd_chk(OFF_INDICATOR, 8'h00, "indicator second reset");
        rd_chk(OFF_SOUNDER, 8'h00, "sounder second reset");
        $display("Test second reset done");
        give_verdict();
    end
endmodule // diag_indicator_ctrl_tb_top

// *** inc/diag_pkg.sv ***
// Package of constants for the diagnostic indicator and buzzer control block
package diag_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;                            // Byte offset width
    localparam int DATA_W = 8;                            // Register width
    localparam logic [ADDR_W-1:0] OFF_INDICATOR = 8'h62;  // indicator_blink_control
    localparam logic [ADDR_W-1:0] OFF_SOUNDER   = 8'h63;  // sounder_alarm_control

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int BIT_ENABLE  = 0;                       // Enable bit
    localparam int SEL_LO      = 1;                       // Pattern select low bit
    localparam int SEL_HI      = 2;                       // Pattern select high bit
    localparam int CTRL_W      = 3;                       // Implemented bits per register
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;      // Both registers reset to zero
    localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;     // Unmapped and reserved read value

    // ------------------------------------------------------------------
    // Pattern select codes (high bit, low bit)
    // ------------------------------------------------------------------
    localparam logic [1:0] PAT_STEADY = 2'h0;             // Steady on / continuous beep
    localparam logic [1:0] PAT_FAST   = 2'h1;             // Fast blink / short beeps
    localparam logic [1:0] PAT_NORMAL = 2'h2;             // Normal blink / normal beeps
    localparam logic [1:0] PAT_LONG   = 2'h3;             // Short blink / long beeps

    // ------------------------------------------------------------------
    // Timing: 10 MHz clock, 1 ms prescaler tick
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 10_000_000;             // System clock rate
    localparam int TICK_US      = 1000;                   // Tick period in microseconds
    localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
    localparam int PRE_W        = 14;                     // Prescaler counter width
    localparam int MS_W         = 11;                     // Millisecond counter width

    // Cadence periods and on-times in milliseconds
    localparam logic [MS_W-1:0] FAST_PERIOD_MS   = 11'd250;
    localparam logic [MS_W-1:0] FAST_ON_MS       = 11'd125;
    localparam logic [MS_W-1:0] NORMAL_PERIOD_MS = 11'd1000;
    localparam logic [MS_W-1:0] NORMAL_ON_MS     = 11'd500;
    localparam logic [MS_W-1:0] SHORT_PERIOD_MS  = 11'd1000;
    localparam logic [MS_W-1:0] SHORT_ON_MS      = 11'd100;
    localparam logic [MS_W-1:0] LONG_PERIOD_MS   = 11'd2000;
    localparam logic [MS_W-1:0] LONG_ON_MS       = 11'd1500;

endpackage : diag_pkg

// *** verilog/cadence_gen.sv ***
// One pattern generator: turns an enable and a select code into an on/off level
`timescale 1ns/100ps
module cadence_gen
    import diag_pkg::*;
#(
    parameter logic [MS_W-1:0] P_FAST   = FAST_PERIOD_MS,   // Period for code 01
    parameter logic [MS_W-1:0] O_FAST   = FAST_ON_MS,       // On-time for code 01
    parameter logic [MS_W-1:0] P_NORMAL = NORMAL_PERIOD_MS, // Period for code 10
    parameter logic [MS_W-1:0] O_NORMAL = NORMAL_ON_MS,     // On-time for code 10
    parameter logic [MS_W-1:0] P_THIRD  = SHORT_PERIOD_MS,  // Period for code 11
    parameter logic [MS_W-1:0] O_THIRD  = SHORT_ON_MS       // On-time for code 11
)(
    input  wire logic       i_clk,     // System clock
    input  wire logic       i_nrst,    // Synchronous reset, active low
    input  wire logic       i_tick,    // One-cycle 1 ms enable
    input  wire logic       i_enable,  // Pattern enabled
    input  wire logic [1:0] i_select,  // Pattern code
    output logic            o_active   // Registered on/off level
);

    // ------------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------------
    logic [MS_W-1:0] phase_q;    // Milliseconds into the current period
    logic [MS_W-1:0] period;     // Selected period
    logic [MS_W-1:0] on_time;    // Selected on-time
    logic [1:0]      select_q;   // Last code, so a change restarts the cadence

    // Period and on-time lookup for the selected code
    always_comb
    begin
        case (i_select)
            PAT_FAST:
            begin
                period  = P_FAST;
                on_time = O_FAST;
            end
            PAT_NORMAL:
            begin
                period  = P_NORMAL;
                on_time = O_NORMAL;
            end
            PAT_LONG:
            begin
                period  = P_THIRD;
                on_time = O_THIRD;
            end
            default:
            begin
                // Steady code: on for the whole period
                period  = P_NORMAL;
                on_time = P_NORMAL;
            end
        endcase
    end

    // Restart at phase zero whenever disabled or the code changes
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst || !i_enable || select_q != i_select)
            phase_q <= '0;
        else if (i_tick)
            phase_q <= (phase_q >= period - 11'd1) ? '0 : phase_q + 11'd1;
    end

    // Code history
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            select_q <= PAT_STEADY;
        else
            select_q <= i_select;
    end

    // Output level: idle while disabled, lit in the first part of each period
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            o_active <= 1'b0;
        else
            o_active <= i_enable && (i_select == PAT_STEADY || phase_q < on_time);
    end

endmodule // cadence_gen

// *** verilog/diag_indicator_ctrl.sv ***
// Diagnostic indicator and buzzer control block with its register file
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module diag_indicator_ctrl
    import diag_pkg::*;
(
    input  wire logic                        i_clk,      // System clock, 10 MHz
    input  wire logic                        i_nrst,     // Synchronous reset, active low
    input  wire logic [diag_pkg::ADDR_W-1:0] i_addr,     // Register byte offset
    input  wire logic [diag_pkg::DATA_W-1:0] i_wdata,    // Write data
    input  wire logic                        i_wr,       // Write strobe
    input  wire logic                        i_rd,       // Read strobe
    output logic      [diag_pkg::DATA_W-1:0] o_rdata,    // Read data, one cycle after strobe
    output logic                             o_led,      // Diagnostic indicator drive
    output logic                             o_buzzer    // Buzzer drive
);
    import diag_pkg::*;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] led_ctrl_q;   // indicator_blink_control implemented bits
    logic [CTRL_W-1:0] buz_ctrl_q;   // sounder_alarm_control implemented bits

    // Register write; upper bits are not stored and read back as zero
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            led_ctrl_q <= CTRL_RESET;
            buz_ctrl_q <= CTRL_RESET;
        end
        else if (i_wr)
        begin
            if (i_addr == OFF_INDICATOR)
                led_ctrl_q <= i_wdata[CTRL_W-1:0];
            if (i_addr == OFF_SOUNDER)
                buz_ctrl_q <= i_wdata[CTRL_W-1:0];
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst || !i_rd)
            o_rdata <= READ_ZERO;
        else if (i_addr == OFF_INDICATOR)
            o_rdata <= {{(DATA_W-CTRL_W){1'b0}}, led_ctrl_q};
        else if (i_addr == OFF_SOUNDER)
            o_rdata <= {{(DATA_W-CTRL_W){1'b0}}, buz_ctrl_q};
        else
            o_rdata <= READ_ZERO;
    end

    // ------------------------------------------------------------------
    // Millisecond prescaler
    // ------------------------------------------------------------------
    logic [PRE_W-1:0] pre_q;    // Divider count
    logic             tick_q;   // One-cycle 1 ms enable

    // Divider shared by both pattern generators, so they stay in step
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (pre_q == PRE_W'(TICK_CYCLES - 1))
        begin
            pre_q  <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            pre_q  <= pre_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pattern generators
    // ------------------------------------------------------------------
    logic led_level;   // Indicator level from its generator
    logic buz_level;   // Buzzer level from its generator

    // Indicator: steady, fast, normal, short blink
    cadence_gen #(
        .P_FAST   (FAST_PERIOD_MS),
        .O_FAST   (FAST_ON_MS),
        .P_NORMAL (NORMAL_PERIOD_MS),
        .O_NORMAL (NORMAL_ON_MS),
        .P_THIRD  (SHORT_PERIOD_MS),
        .O_THIRD  (SHORT_ON_MS)
    ) u_led_gen (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_tick   (tick_q),
        .i_enable (led_ctrl_q[BIT_ENABLE]),
        .i_select (led_ctrl_q[SEL_HI:SEL_LO]),
        .o_active (led_level)
    );

    // Buzzer: continuous, short, normal, long beeps
    cadence_gen #(
        .P_FAST   (FAST_PERIOD_MS),
        .O_FAST   (FAST_ON_MS),
        .P_NORMAL (NORMAL_PERIOD_MS),
        .O_NORMAL (NORMAL_ON_MS),
        .P_THIRD  (LONG_PERIOD_MS),
        .O_THIRD  (LONG_ON_MS)
    ) u_buz_gen (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_tick   (tick_q),
        .i_enable (buz_ctrl_q[BIT_ENABLE]),
        .i_select (buz_ctrl_q[SEL_HI:SEL_LO]),
        .o_active (buz_level)
    );

    // Output flops so the pins come straight from a register
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_led    <= 1'b0;
            o_buzzer <= 1'b0;
        end
        else
        begin
            o_led    <= led_level;
            o_buzzer <= buz_level;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_led_reg_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wr && i_addr == OFF_INDICATOR |=> led_ctrl_q == $past(i_wdata[CTRL_W-1:0]))
        else $error("indicator register write lost");
    a_buz_reg_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wr && i_addr == OFF_SOUNDER |=> buz_ctrl_q == $past(i_wdata[CTRL_W-1:0]))
        else $error("sounder register write lost");
    a_read_back: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_rd && i_addr == OFF_INDICATOR && !i_wr |=> o_rdata == {5'h00, $past(led_ctrl_q)})
        else $error("indicator read data wrong");
    a_led_idle_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !led_ctrl_q[BIT_ENABLE] [*3] |-> !o_led)
        else $error("indicator lit while disabled");
    a_led_steady: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (led_ctrl_q == 3'h1) [*3] |-> o_led)
        else $error("steady indicator not lit");
    a_buz_continuous: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (buz_ctrl_q == 3'h1) [*3] |-> o_buzzer)
        else $error("continuous beep not sounding");
    a_buz_idle_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !buz_ctrl_q[BIT_ENABLE] [*3] |-> !o_buzzer)
        else $error("buzzer sounding while disabled");
    a_tick_period: assert property (@(posedge i_clk) disable iff (!i_nrst)
        tick_q |=> !tick_q [*8])
        else $error("prescaler tick too frequent");
    a_led_blink_starts_on: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(led_ctrl_q[BIT_ENABLE]) && led_ctrl_q[SEL_HI:SEL_LO] == PAT_FAST |-> ##2 o_led)
        else $error("blink did not start lit");

    // ------------------------------------------------------------------
    // Read port shape
    // ------------------------------------------------------------------
    // Read data must fall back to zero whenever no read was strobed
    a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_rd |=> o_rdata == READ_ZERO)
        else $error("read data not idle without strobe");
    // Unmapped offsets read as zero
    a_unmapped_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_rd && i_addr != OFF_INDICATOR && i_addr != OFF_SOUNDER |=> o_rdata == READ_ZERO)
        else $error("unmapped read not zero");
    // Sounder register reads back what it holds
    a_sounder_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_rd && i_addr == OFF_SOUNDER && !i_wr |=> o_rdata == {5'h00, $past(buz_ctrl_q)})
        else $error("sounder read data wrong");
    // Bits above the implemented field never show up on the bus
    a_rdata_upper_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_rdata[DATA_W-1:CTRL_W] == '0)
        else $error("unimplemented read bits set");

    // ------------------------------------------------------------------
    // Register hold
    // ------------------------------------------------------------------
    // A register changes only when its own offset is written
    a_led_reg_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !(i_wr && i_addr == OFF_INDICATOR) |=> $stable(led_ctrl_q))
        else $error("indicator register changed without write");
    a_buz_reg_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !(i_wr && i_addr == OFF_SOUNDER) |=> $stable(buz_ctrl_q))
        else $error("sounder register changed without write");

    // ------------------------------------------------------------------
    // Output path
    // ------------------------------------------------------------------
    // Pins follow their generators by exactly one flop
    a_led_follows_gen: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_led == $past(led_level))
        else $error("indicator pin does not follow generator");
    a_buz_follows_gen: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_buzzer == $past(buz_level))
        else $error("buzzer pin does not follow generator");
    // A cadence always opens in its on phase
    a_led_short_starts_on: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(led_ctrl_q[BIT_ENABLE]) && led_ctrl_q[SEL_HI:SEL_LO] == PAT_LONG |-> ##2 o_led)
        else $error("short blink did not start lit");
    a_buz_long_starts_on: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(buz_ctrl_q[BIT_ENABLE]) && buz_ctrl_q[SEL_HI:SEL_LO] == PAT_LONG |-> ##2 o_buzzer)
        else $error("long beep did not start sounding");

    c_led_fast:   cover property (@(posedge i_clk) led_ctrl_q == 3'h3 && $fell(o_led));
    c_buz_steady: cover property (@(posedge i_clk) buz_ctrl_q == 3'h1 && o_buzzer);
    c_buz_long:   cover property (@(posedge i_clk) buz_ctrl_q == 3'h7 && $rose(o_buzzer));
    c_read_sound: cover property (@(posedge i_clk) i_rd && i_addr == OFF_SOUNDER);

endmodule // diag_indicator_ctrl
